// file: ppl_defines.svh
`ifndef PPL_DEFINES_SVH
`define PPL_DEFINES_SVH
// register byte offsets
`define PPL_A_CTRL 8'h00
`define PPL_A_NLTIM 8'h04
`define PPL_A_NLTHR 8'h08
`define PPL_A_PHCFG 8'h0C
`define PPL_A_FRESP 8'h10
`define PPL_A_DLY 8'h14
`define PPL_A_CLR 8'h18
`define PPL_A_MASK 8'h1C
`define PPL_A_STA 8'h20
`define PPL_A_STB 8'h24
`define PPL_PAGE_ALL 8'hFF
// timing
`define PPL_CLK_NS 10
`define PPL_HICCUP_MS 25
`define PPL_NS_PER_MS 1000000
// field positions
`define PPL_C_ENA 0
`define PPL_C_RESTART_TARGET_SELECT 2
`define PPL_C_BRK 3
`define PPL_C_TRN 4
`define PPL_F_MINON 0
`define PPL_F_MINOFF 8
`define PPL_F_BLANK 16
`define PPL_F_BRKTO 24
`define PPL_F_DINT 0
`define PPL_F_OSR 8
`define PPL_F_UNDERSHOOT_LEVEL_ONE 16
`define PPL_F_UNDERSHOOT_LEVEL_TWO 24
`define PPL_F_PHEN 0
`define PPL_F_MAP 8
`define PPL_F_U1N 16
`define PPL_F_TON 0
`define PPL_F_TOFF 16
`define PPL_S_RUN 8
`define PPL_S_DINT 9
`define PPL_S_LINE 10
`define PPL_SW 8
`define PPL_RW 2
`define PPL_NSRC 6
// reset values and writable masks
`define PPL_RST_CTRL 32'h00000000
`define PPL_RST_NLTIM 32'h20080404
`define PPL_RST_NLTHR 32'h40302010
`define PPL_RST_PHCFG 32'h0001007F
`define PPL_RST_FRESP 32'h00000555
`define PPL_RST_DLY 32'h00640064
`define PPL_RST_MASK 32'h00000000
`define PPL_M_CTRL 32'h0000001F
`define PPL_M_PHCFG 32'h00077F7F
`define PPL_M_FRESP 32'h00000FFF
`define PPL_M_MASK 32'h0000FFFF
`endif

// file: ppl_pkg.sv
package ppl_pkg;
  // channel sequencing states
  typedef enum logic [6:0] {
    CH_OFF = 7'h01,
    CH_TON = 7'h02,
    CH_RUN = 7'h04,
    CH_TOFF = 7'h08,
    CH_LATCH = 7'h10,
    CH_HYST = 7'h20,
    CH_HICC = 7'h40
  } ppl_chst_t;
  // per-source fault response
  typedef enum logic [1:0] {
    RSP_IGNORE = 2'h0,
    RSP_LATCH = 2'h1,
    RSP_HYST = 2'h2,
    RSP_HICC = 2'h3
  } ppl_resp_t;
endpackage : ppl_pkg

// file: ppl_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ppl_phase_timer #(
  parameter int TW = 8 // timer width
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic ce, // clock enable
  input wire logic req, // loop wants pulse high
  input wire logic go, // start granted
  input wire logic trunc, // cut pulse short
  input wire logic halt, // channel stopped or braking
  input wire logic [TW-1:0] min_on, // least on cycles
  input wire logic [TW-1:0] min_off, // least off cycles
  output logic pwm, // pwm level
  output logic ready // may start now
);
  logic pwm_r, pwm_nxt;
  logic [TW-1:0] cnt_r, cnt_nxt, hold_r;

  assign pwm = pwm_r;
  assign ready = !pwm_r && cnt_r == '0 && req && !halt;

  // halt ends a pulse at once; truncation still honours min on
  always_comb begin
    pwm_nxt = pwm_r;
    cnt_nxt = cnt_r;
    if (pwm_r && halt) begin
      pwm_nxt = 1'b0;
      cnt_nxt = min_off;
    end else if (pwm_r) begin
      if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1; // [RULE1]
      else if (!req || trunc) begin // [RULE10]
        pwm_nxt = 1'b0;
        cnt_nxt = min_off; // [RULE2]
      end
    end else if (go && ready) begin
      pwm_nxt = 1'b1;
      cnt_nxt = min_on; // [RULE1]
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1; // [RULE2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce) begin
      pwm_r <= pwm_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // edges spent at the present level, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_r <= '1;
    else if (ce) hold_r <= (pwm_nxt != pwm_r) ? '0 :
      (hold_r == '1 ? hold_r : hold_r + 1'b1);
  end

  property p_min_on;
    @(posedge pclk) disable iff (!presetn)
    ce && pwm_r && !pwm_nxt && !halt |-> hold_r >= min_on;
  endproperty
  a_min_on: assert property (p_min_on) else $error("short pulse"); // [RULE1]

  property p_min_off;
    @(posedge pclk) disable iff (!presetn)
    ce && !pwm_r && pwm_nxt |-> hold_r >= min_off;
  endproperty
  a_min_off: assert property (p_min_off) else $error("short off"); // [RULE2]
endmodule : ppl_phase_timer
`default_nettype wire

// file: ppl_chan_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module ppl_chan_ctl #(
  parameter int CW = 24, // counter width
  parameter int HICC = 2500000 // hiccup wait cycles
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic ce, // clock enable
  input wire logic en, // channel enable
  input wire logic t_latch, // latch-off trip
  input wire logic t_hyst, // hysteretic trip
  input wire logic t_hicc, // hiccup trip
  input wire logic restart_target_select, // restart to boot voltage
  input wire logic [15:0] ton_cyc, // turn-on delay
  input wire logic [15:0] toff_cyc, // turn-off delay
  output ppl_pkg::ppl_chst_t state, // sequencer state
  output logic run, // converting
  output logic boot_sel // target is boot voltage
);
  import ppl_pkg::*;
  ppl_chst_t st_r;
  logic [CW-1:0] cnt_r;
  logic boot_r;
  logic trip;

  assign trip = t_latch || t_hyst || t_hicc;
  assign state = st_r;
  assign run = st_r == CH_RUN || st_r == CH_TOFF;
  assign boot_sel = boot_r;

  // fault exits skip the turn-off delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= CH_OFF;
      cnt_r <= '0;
      boot_r <= 1'b0;
    end else if (ce) begin
      case (st_r)
        CH_OFF: if (en) begin
          st_r <= CH_TON; // [RULE18]
          cnt_r <= CW'(ton_cyc);
        end
        CH_TON, CH_RUN, CH_TOFF: if (trip) begin // [RULE22]
          if (t_latch) st_r <= CH_LATCH; // [RULE18]
          else if (t_hicc) begin
            st_r <= CH_HICC; // [RULE21]
            cnt_r <= CW'(HICC);
          end else st_r <= CH_HYST; // [RULE20]
        end else if (st_r == CH_TOFF) begin
          if (cnt_r == '0) st_r <= CH_OFF;
          else cnt_r <= cnt_r - 1'b1;
        end else if (!en) begin
          st_r <= (st_r == CH_RUN) ? CH_TOFF : CH_OFF;
          cnt_r <= CW'(toff_cyc);
          boot_r <= 1'b0;
        end else if (st_r == CH_TON) begin
          if (cnt_r == '0) st_r <= CH_RUN;
          else cnt_r <= cnt_r - 1'b1;
        end
        CH_LATCH: if (!en) begin
          st_r <= CH_OFF; // [RULE18]
          boot_r <= restart_target_select; // [RULE19]
        end
        CH_HYST: if (!en) st_r <= CH_OFF;
        else if (!t_hyst) begin
          st_r <= CH_TON; // [RULE20]
          cnt_r <= CW'(ton_cyc);
        end
        CH_HICC: if (!en) st_r <= CH_OFF;
        else if (cnt_r == '0) begin
          st_r <= CH_TON; // [RULE21]
          cnt_r <= CW'(ton_cyc);
          boot_r <= restart_target_select; // [RULE19]
        end else cnt_r <= cnt_r - 1'b1;
        default: st_r <= CH_OFF;
      endcase
    end
  end

  property p_no_toff;
    @(posedge pclk) disable iff (!presetn)
    ce && run && trip |=> st_r inside {CH_LATCH, CH_HYST, CH_HICC};
  endproperty
  a_no_toff: assert property (p_no_toff) else $error("toff used"); // [RULE22]

  property p_latch_exit;
    @(posedge pclk) disable iff (!presetn)
    $past(st_r) == CH_LATCH && st_r != CH_LATCH |->
      st_r == CH_OFF && !$past(en);
  endproperty
  a_latch_exit: assert property (p_latch_exit) // [RULE18]
    else $error("latch left early");

  property p_hicc_wait;
    @(posedge pclk) disable iff (!presetn)
    $past(st_r) == CH_HICC && st_r == CH_TON |-> $past(cnt_r) == '0;
  endproperty
  a_hicc_wait: assert property (p_hicc_wait) // [RULE21]
    else $error("hiccup cut short");
endmodule : ppl_chan_ctl
`default_nettype wire

// file: ppl_core.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_defines.svh"
// What the document asks of this block
// RULE1: each pulse held high min on-time
// RULE2: new pulse waits min off-time
// RULE3: blanking delays pulse after previous one
// RULE4: min on, off, blanking programmable
// RULE5: pulse rate bounded by blanking, off-time
// RULE6: overshoot past threshold selects alternate integration
// RULE7: level one adds configured extra phases
// RULE8: level two enables all channel phases
// RULE9: diode braking tri-states channel pwm pins
// RULE10: braking, truncation, threshold, timeout are settings
// RULE11: unmasked status bit asserts alert line
// RULE12: host finds alerter by alert response; this block has no alert response, only the status words
// RULE13: clear command, disable, reset clear status
// RULE14: paged fault stops only its channel
// RULE15: shared fault stops both channels
// RULE16: warnings flag only, conversion continues
// RULE17: ignore response behaves like warning
// RULE18: latch-off holds until enable toggled
// RULE19: restart target option after latch, hiccup
// RULE20: hysteretic restarts when condition clears
// RULE21: hiccup waits then retries forever
// RULE22: fault shutdown skips turn-off delay
// RULE23: clear loses to a present condition
// RULE24: status bits stay set until cleared
module ppl_core #(
  parameter int NPH = 7, // pwm phases
  parameter int HICC_CYC =
    `PPL_HICCUP_MS * (`PPL_NS_PER_MS / `PPL_CLK_NS) // hiccup cycles
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic ce, // clock enable
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [NPH-1:0] pwm_req, // loop pulse requests
  input wire logic [NPH-1:0] shed_act, // phases kept by shedding
  input wire logic [7:0] dev_a, // chan a signed deviation
  input wire logic [7:0] dev_b, // chan b signed deviation
  input wire logic [3:0] pflt_a, // chan a fault conditions
  input wire logic [3:0] pflt_b, // chan b fault conditions
  input wire logic [1:0] sflt, // shared fault conditions
  input wire logic [1:0] warn_a, // chan a warnings
  input wire logic [1:0] warn_b, // chan b warnings
  output logic [NPH-1:0] pwm_o, // pwm levels
  output logic [NPH-1:0] pwm_oe, // pwm drive enables
  input wire logic alert_i, // alert line level
  output logic alert_o, // alert drive value
  output logic alert_oe, // alert pull-down enable
  output logic int_alt_a, // chan a alternate integration
  output logic int_alt_b, // chan b alternate integration
  output logic run_a, // chan a converting
  output logic run_b, // chan b converting
  output logic boot_sel_a, // chan a target is boot voltage
  output logic boot_sel_b // chan b target is boot voltage
);
  import ppl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] wmask(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : wmask

  function automatic logic [NPH-1:0] first_n(input logic [NPH-1:0] m,
    input logic [2:0] n);
    logic [2:0] k;
    logic [NPH-1:0] r;
    k = n;
    r = '0;
    for (int i = 0; i < NPH; i++) begin
      if (m[i] && k != 3'h0) begin
        r[i] = 1'b1;
        k = k - 3'h1;
      end
    end
    return r;
  endfunction : first_n

  function automatic logic over_thr(input logic [7:0] d,
    input logic [7:0] t);
    return $signed({d[7], d}) > $signed({1'b0, t});
  endfunction : over_thr

  function automatic logic under_thr(input logic [7:0] d,
    input logic [7:0] t);
    return $signed({d[7], d}) < -$signed({1'b0, t});
  endfunction : under_thr

  ////////////////////////////////////////////////////////////////////////
  // registers and apb slave
  logic [31:0] ctrl_r, tim_r, thr_r, phc_r, rsp_r, dly_r, msk_r;
  logic [31:0] prdata_r, rd_nxt;
  logic ack_r, err_r, err_nxt, wr, clr_wr;
  logic [7:0] sts_r [2];
  logic [31:0] sta_v [2];
  logic [1:0] run_v, dint_r, en_v, en_q, boot_v;
  logic alert_r;

  assign pready = ce && ack_r && penable;
  assign prdata = prdata_r;
  assign pslverr = err_r && pready;
  assign wr = psel && penable && pwrite && pready;
  assign clr_wr = wr && paddr == `PPL_A_CLR && pstrb[0];
  assign en_v = ctrl_r[`PPL_C_ENA +: 2];

  // status words, reserved bits read zero
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      sta_v[c] = '0;
      sta_v[c][`PPL_SW-1:0] = sts_r[c];
      sta_v[c][`PPL_S_RUN] = run_v[c];
      sta_v[c][`PPL_S_DINT] = dint_r[c];
      sta_v[c][`PPL_S_LINE] = alert_i;
    end
  end

  // read decode, unmapped answers with slverr
  always_comb begin
    rd_nxt = '0;
    err_nxt = 1'b0;
    case (paddr)
      `PPL_A_CTRL: rd_nxt = ctrl_r;
      `PPL_A_NLTIM: rd_nxt = tim_r;
      `PPL_A_NLTHR: rd_nxt = thr_r;
      `PPL_A_PHCFG: rd_nxt = phc_r;
      `PPL_A_FRESP: rd_nxt = rsp_r;
      `PPL_A_DLY: rd_nxt = dly_r;
      `PPL_A_CLR: rd_nxt = '0;
      `PPL_A_MASK: rd_nxt = msk_r;
      `PPL_A_STA: rd_nxt = sta_v[0];
      `PPL_A_STB: rd_nxt = sta_v[1];
      default: err_nxt = 1'b1;
    endcase
  end

  // read data captured before the access phase: no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      prdata_r <= '0;
    end else if (ce) begin
      if (psel && !ack_r) begin
        ack_r <= 1'b1;
        err_r <= err_nxt;
        prdata_r <= pwrite ? '0 : rd_nxt;
      end else if (!psel || pready) begin
        ack_r <= 1'b0;
      end
    end
  end

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `PPL_RST_CTRL;
      tim_r <= `PPL_RST_NLTIM;
      thr_r <= `PPL_RST_NLTHR;
      phc_r <= `PPL_RST_PHCFG;
      rsp_r <= `PPL_RST_FRESP;
      dly_r <= `PPL_RST_DLY;
      msk_r <= `PPL_RST_MASK;
    end else if (wr) begin
      case (paddr)
        `PPL_A_CTRL: ctrl_r <= wmask(ctrl_r, pwdata, pstrb) & `PPL_M_CTRL;
        `PPL_A_NLTIM: tim_r <= wmask(tim_r, pwdata, pstrb); // [RULE4]
        `PPL_A_NLTHR: thr_r <= wmask(thr_r, pwdata, pstrb); // [RULE10]
        `PPL_A_PHCFG: phc_r <= wmask(phc_r, pwdata, pstrb) & `PPL_M_PHCFG;
        `PPL_A_FRESP: rsp_r <= wmask(rsp_r, pwdata, pstrb) & `PPL_M_FRESP;
        `PPL_A_DLY: dly_r <= wmask(dly_r, pwdata, pstrb);
        `PPL_A_MASK: msk_r <= wmask(msk_r, pwdata, pstrb) & `PPL_M_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transient aids per channel
  logic [7:0] dev [2];
  logic [NPH-1:0] own_v [2];
  logic [NPH-1:0] act_v [2];
  logic [NPH-1:0] map;
  logic [1:0] osr_hit, brk_r, arm_r;
  logic [7:0] bcnt_r [2];

  assign dev[0] = dev_a;
  assign dev[1] = dev_b;
  assign map = phc_r[`PPL_F_MAP +: NPH];

  // phase ownership and fast phase adding
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      own_v[c] = phc_r[`PPL_F_PHEN +: NPH] & (c == 1 ? map : ~map);
      osr_hit[c] = over_thr(dev[c], thr_r[`PPL_F_OSR +: 8]);
      if (under_thr(dev[c], thr_r[`PPL_F_UNDERSHOOT_LEVEL_TWO +: 8])) begin
        act_v[c] = own_v[c]; // [RULE8]
      end else if (under_thr(dev[c], thr_r[`PPL_F_UNDERSHOOT_LEVEL_ONE +: 8])) begin
        act_v[c] = own_v[c] & (shed_act | first_n(own_v[c] & ~shed_act,
          phc_r[`PPL_F_U1N +: 3])); // [RULE7]
      end else begin
        act_v[c] = own_v[c] & shed_act;
      end
    end
  end

  // alternate integration while overshoot exceeds its threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dint_r <= '0;
    else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        dint_r[c] <= over_thr(dev[c], thr_r[`PPL_F_DINT +: 8]); // [RULE6]
      end
    end
  end

  // diode braking, capped by timeout; rearms once overshoot ends
  // to bound heating under repeated transients
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_r <= '0;
      arm_r <= '1;
      bcnt_r[0] <= '0;
      bcnt_r[1] <= '0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (brk_r[c]) begin
          if (!osr_hit[c] || bcnt_r[c] == '0) brk_r[c] <= 1'b0; // [RULE10]
          else bcnt_r[c] <= bcnt_r[c] - 1'b1;
        end else if (ctrl_r[`PPL_C_BRK] && osr_hit[c] && arm_r[c] &&
          run_v[c]) begin
          brk_r[c] <= 1'b1; // [RULE9]
          bcnt_r[c] <= tim_r[`PPL_F_BRKTO +: 8];
          arm_r[c] <= 1'b0;
        end
        if (!osr_hit[c]) arm_r[c] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase timers and adjacent-phase blanking
  logic [NPH-1:0] req_v, halt_v, trunc_v, ready_v, go_v;
  logic [7:0] blk_r [2];
  logic [8:0] gap_r [2];
  logic [1:0] gnt_c;

  // stopped or braking channels float their pins
  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      req_v[i] = pwm_req[i] && act_v[map[i]][i];
      halt_v[i] = !run_v[map[i]] || brk_r[map[i]]; // [RULE9]
      trunc_v[i] = ctrl_r[`PPL_C_TRN] && osr_hit[map[i]]; // [RULE10]
    end
    go_v = '0;
    for (int c = 0; c < 2; c++) begin
      if (blk_r[c] == '0) go_v = go_v | first_n(ready_v & own_v[c], 3'h1);
      gnt_c[c] = |(go_v & own_v[c]);
    end
  end
  assign pwm_oe = ~halt_v;

  generate
    for (genvar i = 0; i < NPH; i++) begin : g_ph
      ppl_phase_timer #(.TW(8)) u_ph (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .req(req_v[i]),
        .go(go_v[i]),
        .trunc(trunc_v[i]),
        .halt(halt_v[i]),
        .min_on(tim_r[`PPL_F_MINON +: 8]), // [RULE4]
        .min_off(tim_r[`PPL_F_MINOFF +: 8]), // [RULE4]
        .pwm(pwm_o[i]),
        .ready(ready_v[i])
      );
    end
  endgenerate

  // one start per channel, then blanking before the next phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_r[0] <= '0;
      blk_r[1] <= '0;
      gap_r[0] <= '1;
      gap_r[1] <= '1;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (gnt_c[c]) blk_r[c] <= tim_r[`PPL_F_BLANK +: 8]; // [RULE3] [RULE5]
        else if (blk_r[c] != '0) blk_r[c] <= blk_r[c] - 1'b1;
        gap_r[c] <= gnt_c[c] ? '0 :
          (gap_r[c] == '1 ? gap_r[c] : gap_r[c] + 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault responses, status and alert
  logic [`PPL_NSRC-1:0] cond [2];
  logic [1:0] tl, th, tc, clr_v;
  logic sh_tl;
  logic [7:0] set_v [2];
  ppl_resp_t rsp;
  ppl_chst_t st_v [2];

  // shared sources reach both channels, paged only their own
  always_comb begin
    sh_tl = 1'b0;
    rsp = RSP_IGNORE;
    for (int c = 0; c < 2; c++) begin
      cond[c] = {sflt, c == 1 ? pflt_b : pflt_a}; // [RULE14] [RULE15]
      set_v[c] = {c == 1 ? warn_b : warn_a, cond[c]}; // [RULE16] [RULE17]
      tl[c] = 1'b0;
      th[c] = 1'b0;
      tc[c] = 1'b0;
      for (int k = 0; k < `PPL_NSRC; k++) begin
        rsp = ppl_resp_t'(rsp_r[`PPL_RW*k +: `PPL_RW]);
        if (cond[c][k]) begin
          case (rsp)
            RSP_LATCH: tl[c] = 1'b1;
            RSP_HYST: th[c] = 1'b1;
            RSP_HICC: tc[c] = 1'b1;
            default: ; // ignore keeps converting
          endcase
        end
      end
      clr_v[c] = (clr_wr && (pwdata[7:0] == 8'(c) ||
        pwdata[7:0] == `PPL_PAGE_ALL)) || (en_q[c] && !en_v[c]); // [RULE13]
    end
    for (int k = 4; k < `PPL_NSRC; k++) begin
      if (sflt[k-4] && rsp_r[`PPL_RW*k +: `PPL_RW] == RSP_LATCH) sh_tl = 1'b1;
    end
  end

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      ppl_chan_ctl #(.CW(24), .HICC(HICC_CYC)) u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .en(en_v[c]),
        .t_latch(tl[c]),
        .t_hyst(th[c]),
        .t_hicc(tc[c]),
        .restart_target_select(ctrl_r[`PPL_C_RESTART_TARGET_SELECT]),
        .ton_cyc(dly_r[`PPL_F_TON +: 16]),
        .toff_cyc(dly_r[`PPL_F_TOFF +: 16]),
        .state(st_v[c]),
        .run(run_v[c]),
        .boot_sel(boot_v[c])
      );
    end
  endgenerate

  // sticky bits; a live condition wins over the clear [RULE23]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r[0] <= '0;
      sts_r[1] <= '0;
      en_q <= '0;
      alert_r <= 1'b0;
    end else if (ce) begin
      en_q <= en_v;
      for (int c = 0; c < 2; c++) begin
        sts_r[c] <= (sts_r[c] & ~{`PPL_SW{clr_v[c]}}) | set_v[c]; // [RULE24]
      end
      alert_r <= |((sts_r[0] & ~msk_r[0 +: `PPL_SW]) |
        (sts_r[1] & ~msk_r[`PPL_SW +: `PPL_SW])); // [RULE11]
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe = alert_r;
  assign int_alt_a = dint_r[0];
  assign int_alt_b = dint_r[1];
  assign run_a = run_v[0];
  assign run_b = run_v[1];
  assign boot_sel_a = boot_v[0];
  assign boot_sel_b = boot_v[1];

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_blank;
    @(posedge pclk) disable iff (!presetn)
    ce && gnt_c[0] |-> gap_r[0] >= {1'b0, tim_r[`PPL_F_BLANK +: 8]};
  endproperty
  a_blank: assert property (p_blank) else $error("blank too short"); // [RULE3]

  property p_brake;
    @(posedge pclk) disable iff (!presetn)
    brk_r[0] |-> (pwm_oe & own_v[0]) == '0;
  endproperty
  a_brake: assert property (p_brake) else $error("braked pin on"); // [RULE9]

  property p_alert;
    @(posedge pclk) disable iff (!presetn)
    ce && |(sts_r[0] & ~msk_r[0 +: `PPL_SW]) |=> alert_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing"); // [RULE11]

  property p_shared;
    @(posedge pclk) disable iff (!presetn)
    ce && sh_tl |=> run_v == 2'b00;
  endproperty
  a_shared: assert property (p_shared) else $error("run not low"); // [RULE15]

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    ce && !clr_v[1] |=> (sts_r[1] & $past(sts_r[1])) == $past(sts_r[1]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost"); // [RULE24]
endmodule : ppl_core
`default_nettype wire

// file: ppl_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: power stages on pwm pins, pulled-up alert wire to host
module ppl_stage_model (
  input wire logic alert_oe, // device pulls alert low
  input wire logic [6:0] pwm_o, // pwm levels
  input wire logic [6:0] pwm_oe, // pwm drive enables
  output logic alert_i, // resolved alert wire
  output logic [6:0] stage_on // high side switch on
);
  // pull-up wins unless someone pulls low; host then polls alert
  assign alert_i = alert_oe ? 1'b0 : 1'b1;
  // floated pin leaves both switches off (diode braking)
  assign stage_on = pwm_o & pwm_oe;
endmodule : ppl_stage_model
`default_nettype wire

// file: test_ppl_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_ppl_core;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, dev_a = 0, dev_b = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h66bf846a;
  logic pready, pslverr, er, alert_i, alert_o, alert_oe;
  logic [6:0] pwm_req = 0, shed_act = 7'h7F, pwm_o, pwm_oe, stage_on;
  logic [3:0] pflt_a = 0, pflt_b = 0;
  logic [1:0] sflt = 0, warn_a = 0, warn_b = 0;
  logic run_a, run_b, ia, ib, ba, bb;
  int err_total = 0, n_checks = 0, k, n, mo;
  ppl_core #(.NPH(7), .HICC_CYC(50)) ppl_core_inst (.pclk(pclk),
    .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_req(pwm_req), .shed_act(shed_act), .dev_a(dev_a), .dev_b(dev_b),
    .pflt_a(pflt_a), .pflt_b(pflt_b), .sflt(sflt), .warn_a(warn_a),
    .warn_b(warn_b), .pwm_o(pwm_o), .pwm_oe(pwm_oe), .alert_i(alert_i),
    .alert_o(alert_o), .alert_oe(alert_oe), .int_alt_a(ia),
    .int_alt_b(ib), .run_a(run_a), .run_b(run_b), .boot_sel_a(ba),
    .boot_sel_b(bb));
  ppl_stage_model ppl_stage_model_inst (.alert_oe(alert_oe),
    .pwm_o(pwm_o), .pwm_oe(pwm_oe), .alert_i(alert_i),
    .stage_on(stage_on));
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // bounded wait for both channel run flags to reach a level
  task wrun(input logic [1:0] v);
    for (k = 0; k < 60 && {run_a, run_b} !== v; k++) @(posedge pclk);
  endtask : wrun
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // watchdog far beyond the expected few hundred cycles
  initial begin
    #300000;
    err_total++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h08, 0); chk(rd, 32'h40302010);
    apb(0, 8'h14, 0); chk(rd, 32'h00640064);
    apb(0, 8'h40, 0); chk(er, 1); chk(rd, 0);
    $display("test regs done");
    // random min on-time, short delays so sequencing is quick
    mo = 4 + ($random(seed) & 7);
    apb(1, 8'h14, 32'h00030003);
    apb(1, 8'h04, 32'h40020200 | mo);
    apb(1, 8'h00, 32'h3);
    wrun(2'b11); chk({run_a, run_b}, 2'b11);
    // one-cycle request must still give a full minimum pulse
    pwm_req[0] <= 1; @(posedge pclk); pwm_req[0] <= 0;
    for (k = 0; k < 20 && pwm_o[0] !== 1'b1; k++) @(posedge pclk);
    for (n = 0; n < 40 && pwm_o[0] === 1'b1; n++) @(posedge pclk);
    chk(n > mo, 1);
    $display("test min on done");
    warn_a <= 2'b01; @(posedge pclk); warn_a <= 0;
    repeat (3) @(posedge pclk);
    apb(0, 8'h20, 0); chk(rd[6], 1);
    chk(run_a, 1);
    chk({alert_o, alert_i}, 0);
    // random overshoot above the integration threshold on channel a
    dev_a <= 8'h11 + 8'($random(seed) & 8'h3F);
    repeat (2) @(posedge pclk); dev_a <= 0;
    chk({ia, ib}, 2'b10);
    $display("test warning done");
    // paged latch-off: only channel a stops, clear loses while present
    pflt_a[0] <= 1; repeat (3) @(posedge pclk);
    chk({run_a, run_b}, 2'b01);
    apb(1, 8'h18, 32'h0); apb(0, 8'h20, 0); chk(rd[0], 1);
    pflt_a[0] <= 0;
    apb(1, 8'h18, 32'hFF); apb(0, 8'h20, 0); chk(rd[7:0], 0);
    chk(run_a, 0);
    // leave latch with the boot target option set
    apb(1, 8'h00, 32'h6); apb(1, 8'h00, 32'h3);
    chk(run_a, 0);
    wrun(2'b11); chk(run_a, 1);
    chk(pwm_oe, 7'h7F);
    chk({ba, bb}, 2'b10);
    $display("test latch done");
    // overshoot with braking on floats every channel a pin
    apb(1, 8'h00, 32'hB); dev_a <= 8'h7F;
    repeat (2) @(posedge pclk); dev_a <= 0;
    chk({stage_on, pwm_oe}, 0);
    // hiccup: stopped through the wait, then retried via turn-on delay
    apb(1, 8'h10, 32'h55D); pflt_a[1] <= 1;
    repeat (3) @(posedge pclk); pflt_a[1] <= 0;
    repeat (40) @(posedge pclk); chk(run_a, 0);
    wrun(2'b11); chk(run_a, 1);
    $display("test brake hiccup done");
    sflt[0] <= 1; repeat (3) @(posedge pclk);
    chk({run_a, run_b}, 2'b00);
    $display("test shared done");
    final_report;
  end
endmodule : test_ppl_core
`default_nettype wire
